// file: verilog/adc_backend_pkg.sv
// constants, field layouts and state codes shared by the converter back end
package adc_backend_pkg;
    localparam int NUM_CH = 4;
    // oscillator divide and clock-presence watchdog
    localparam logic [2:0] DIV_LAST = 3'h7;
    localparam int CORE_CLK_MHZ = 100;
    localparam int EXT_CLK_MIN_MHZ = 20;
    localparam logic [4:0] CLK_LOSS_CYCLES = 5'(2 * CORE_CLK_MHZ / EXT_CLK_MIN_MHZ);
    // register byte addresses
    localparam logic [7:0] ADDR_CFG = 8'h00;
    localparam logic [7:0] ADDR_RATE = 8'h04;
    localparam logic [7:0] ADDR_DELAY = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0c;
    localparam logic [7:0] ADDR_DATA0 = 8'h10;
    localparam logic [7:0] ADDR_DATA3 = 8'h1c;
    // field positions
    localparam int CFG_XTAL_BIT = 0;
    localparam int CFG_FDIS_BIT = 1;
    localparam int STAT_CLK_BIT = 0;
    localparam int STAT_FAULT_BIT = 1;
    localparam int STAT_OVF_BIT = 2;
    localparam int STAT_READY_BIT = 3;
    localparam int STAT_PIN_BIT = 4;
    localparam int DELAY_W = 6;
    localparam int DLINE_LEN = 64;
    // decimation: ratio is 16 shl rate code
    localparam int RATE_W = 3;
    localparam int RATE_MIN_LOG2 = 4;
    localparam logic [11:0] RATE_MIN = 12'h010;
    localparam int CIC_W = 36;
    localparam int SMP_W = 24;
    localparam int WIDE_W = 48;
    localparam int ACC_W = 40;
    localparam int COEF_W = 12;
    localparam int NORM_BITS = 23;
    localparam int FIR_SHIFT = 10;
    localparam logic [3:0] FIR_LAST_TAP = 4'h8;
    localparam logic [3:0] FIR_TAPS = 4'h9;
    localparam logic [23:0] SAT_CODE = 24'h7fffff;
    localparam logic [23:0] FS_CODE = 24'h70a3d7;
    localparam logic [4:0] FAULT_REC_LAST = 5'h15;
    localparam int MEM_AW = 6;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_WRITE = 5'b00010,
        ST_READ = 5'b00100,
        ST_MAC = 5'b01000,
        ST_STORE = 5'b10000
    } fir_state_t;

    // filter taps scaled by 1024, symmetric about the centre tap
    function automatic logic signed [COEF_W-1:0] fir_coef(input logic [3:0] k);
        logic [3:0] m;
        m = (k > 4'h4) ? 4'(FIR_LAST_TAP - k) : k;
        unique case (m)
            4'h0: fir_coef = 12'sh017;
            4'h1: fir_coef = -12'sh04c;
            4'h2: fir_coef = -12'sh025;
            4'h3: fir_coef = 12'sh13f;
            default: fir_coef = 12'sh235;
        endcase
    endfunction : fir_coef
endpackage : adc_backend_pkg

// file: verilog/tap_mem_if.sv
// port bundle between the filter engine and its tap history memory
`timescale 1ns/1ns
`default_nettype none
interface tap_mem_if;
    logic wr_en;
    logic [adc_backend_pkg::MEM_AW-1:0] wr_addr;
    logic [adc_backend_pkg::SMP_W-1:0] wr_data;
    logic [adc_backend_pkg::MEM_AW-1:0] rd_addr;
    logic [adc_backend_pkg::SMP_W-1:0] rd_data;
    modport engine(output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport store(input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface : tap_mem_if
`default_nettype wire

// file: verilog/tap_history_mem.sv
// per-channel sample history for the fir stage, registered read port
`timescale 1ns/1ns
`default_nettype none
module tap_history_mem (
    input wire logic clk_i,
    input wire logic rst_n_i,
    tap_mem_if.store mem
);
    typedef struct packed {
        logic [(1 << adc_backend_pkg::MEM_AW)-1:0][adc_backend_pkg::SMP_W-1:0] words;
        logic [adc_backend_pkg::SMP_W-1:0] rd_data;
    } mem_state_t;

    mem_state_t q;
    mem_state_t n;

    // read returns the word as stored before any write in the same cycle
    always_comb begin
        n = q;
        n.rd_data = q.words[mem.rd_addr];
        if (mem.wr_en) begin
            n.words[mem.wr_addr] = mem.wr_data;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign mem.rd_data = q.rd_data;
endmodule : tap_history_mem
`default_nettype wire

// file: verilog/adc_backend.sv
// decimation, clock source and overflow/fault flag logic of the four-channel converter
// What this block does
// RL1 - modulator clock is the oscillator input clock divided by eight
// RL2 - each channel decimates its modulator bitstream into 24-bit samples
// RL3 - filter is a third-order sinc followed by an fir stage
// RL4 - fir runs at output rate with the nine listed symmetric taps
// RL5 - filter corners scale with output rate since it sets the decimation
// RL6 - output data rate is chosen by software
// RL7 - each channel has its own programmable sampling delay
// RL8 - crystal enable bit set runs the on-chip oscillator
// RL9 - crystal enable clear means external clock, buffered output released
// RL10 - in crystal mode buffered output carries the oscillator clock
// RL11 - result beyond full scale is clipped and overflow flag driven low
// RL12 - overflow flag appears together with ready of the clipped result
// RL13 - fault input with protection on engages protection, fault flag low
// RL14 - protection disable bit turns off protection and fault reporting
// RL15 - clipping and fault clamping act on the affected channel only
// RL16 - overflow flag goes low together with the fault flag while an input clock runs
// RL17 - overflow flag is not driven while no input clock runs
// RL18 - overflow flag is active-low open drain for wired combination
// RL19 - fault flag releases 20 to 25 output periods after inputs recover
// RL20 - all channels decimate by modulator rate over output rate
//
// Added by the designer: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module adc_backend (
    input wire logic CORE_CLK_I,
    input wire logic RST_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    input wire logic [3:0] PSTRB_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic OSC_CLOCK_INPUT_I,
    output logic CRYSTAL_DRIVE_PIN_O,
    output logic CRYSTAL_DRIVE_PIN_OE_O,
    output logic BUFFERED_OSC_OUT_O,
    output logic BUFFERED_OSC_OUT_OE_O,
    input wire logic [3:0] MOD_BITS_I,
    input wire logic [3:0] FAULT_POS_I,
    input wire logic [3:0] FAULT_NEG_I,
    output logic [3:0] PROTECT_ENGAGE_O,
    input wire logic OVERFLOW_FLAG_N_I,
    output logic OVERFLOW_FLAG_N_O,
    output logic OVERFLOW_FLAG_N_OE_O,
    output logic FAULT_FLAG_N_O,
    output logic RESULT_READY_OUT_N_O
);
    typedef struct packed {
        logic osc_s1, osc_s2, osc_s3, osc_buf;
        logic [3:0] mbit_s1, mbit_s2, fpos_s1, fpos_s2, fneg_s1, fneg_s2;
        logic ovf_s1, ovf_s2;
        logic [2:0] div_cnt;
        logic [4:0] watchdog;
        logic clk_valid;
        logic cfg_xtal, cfg_fdis;
        logic [adc_backend_pkg::RATE_W-1:0] rate_code;
        logic [3:0][adc_backend_pkg::DELAY_W-1:0] delay;
        logic [3:0][adc_backend_pkg::DLINE_LEN-1:0] dline;
        logic [3:0][2:0][adc_backend_pkg::CIC_W-1:0] integ;
        logic [3:0][2:0][adc_backend_pkg::CIC_W-1:0] comb;
        logic [10:0] dec_cnt;
        logic [3:0][adc_backend_pkg::SMP_W-1:0] pend;
        adc_backend_pkg::fir_state_t fsm;
        logic [1:0] ch;
        logic [3:0] tap, wptr;
        logic [adc_backend_pkg::ACC_W-1:0] acc;
        logic [3:0][adc_backend_pkg::SMP_W-1:0] result;
        logic [3:0] clip;
        logic ovf_clip;
        logic [3:0] fault_act, fault_dir;
        logic [3:0][4:0] fault_cnt;
        logic ready;
        logic [31:0] prdata;
        logic slverr;
    } core_state_t;

    core_state_t q;
    core_state_t n;
    tap_mem_if mem ();

    logic osc_rise;
    logic mod_tick;
    logic dec_tick;
    logic setup_ph;
    logic access_ph;
    logic ovf_drive;

    // saturate a wide signed value to plus or minus lim; top bit flags a clip
    function automatic logic [24:0] clip_to(input logic signed [47:0] x, input logic [23:0] lim);
        logic signed [47:0] hi;
        hi = $signed({24'h000000, lim});
        if (x > hi) begin
            clip_to = {1'b1, lim};
        end else if (x < -hi) begin
            clip_to = {1'b1, 24'(-$signed({1'b0, lim}))};
        end else begin
            clip_to = {1'b0, x[23:0]};
        end
    endfunction : clip_to

    // normalise the sinc output by the ratio cubed into a 24-bit sample
    function automatic logic [23:0] to_sample(input logic [35:0] c, input logic [2:0] code);
        int sh;
        logic signed [47:0] w;
        logic [24:0] r;
        sh = 3 * (adc_backend_pkg::RATE_MIN_LOG2 + int'(code)) - adc_backend_pkg::NORM_BITS;
        w = $signed({{12{c[35]}}, c});
        if (sh >= 0) begin
            w = w >>> sh;
        end else begin
            w = w <<< (-sh);
        end
        r = clip_to(w, adc_backend_pkg::SAT_CODE);
        to_sample = r[23:0];
    endfunction : to_sample

    // history index of the sample k taps back from the write pointer
    function automatic logic [3:0] back9(input logic [3:0] p, input logic [3:0] k);
        logic [4:0] d;
        d = {1'b0, p} + {1'b0, adc_backend_pkg::FIR_TAPS} - {1'b0, k};
        if (d >= {1'b0, adc_backend_pkg::FIR_TAPS}) begin
            d = d - {1'b0, adc_backend_pkg::FIR_TAPS};
        end
        back9 = d[3:0];
    endfunction : back9

    tap_history_mem u_hist (
        .clk_i(CORE_CLK_I),
        .rst_n_i(RST_N_I),
        .mem(mem.store)
    );

    assign setup_ph = PSEL_I & ~PENABLE_I;
    assign access_ph = PSEL_I & PENABLE_I;
    assign osc_rise = q.osc_s2 & ~q.osc_s3;
    assign mod_tick = osc_rise && (q.div_cnt == adc_backend_pkg::DIV_LAST); // RL1
    // one ratio for every channel, so all four publish together
    assign dec_tick = mod_tick && (q.dec_cnt == 11'(((adc_backend_pkg::RATE_MIN << q.rate_code) - 12'h001))); // RL20 RL6

    // whole next-state computation
    always_comb begin
        logic step_bit;
        logic signed [35:0] c1, c2, c3;
        logic signed [47:0] y;
        logic [24:0] cr;
        n = q;
        step_bit = 1'b0;
        c1 = '0;
        c2 = '0;
        c3 = '0;
        y = '0;
        cr = '0;
        mem.wr_en = 1'b0;
        mem.wr_addr = {q.ch, q.wptr};
        mem.wr_data = q.pend[q.ch];
        mem.rd_addr = {q.ch, back9(q.wptr, q.tap)};
        // pin synchronisers
        n.osc_s1 = OSC_CLOCK_INPUT_I;
        n.osc_s2 = q.osc_s1;
        n.osc_s3 = q.osc_s2;
        n.mbit_s1 = MOD_BITS_I;
        n.mbit_s2 = q.mbit_s1;
        n.fpos_s1 = FAULT_POS_I;
        n.fpos_s2 = q.fpos_s1;
        n.fneg_s1 = FAULT_NEG_I;
        n.fneg_s2 = q.fneg_s1;
        n.ovf_s1 = OVERFLOW_FLAG_N_I;
        n.ovf_s2 = q.ovf_s1;
        // sampled copy of the oscillator; jitter is one core period, fine for the modulators
        n.osc_buf = q.osc_s2; // RL10
        // clock presence: no rising edge for two slowest periods means lost
        if (osc_rise) begin
            n.watchdog = '0;
            n.clk_valid = 1'b1;
        end else if (q.watchdog == adc_backend_pkg::CLK_LOSS_CYCLES) begin
            n.clk_valid = 1'b0; // RL17
        end else begin
            n.watchdog = q.watchdog + 5'h01;
        end
        if (osc_rise) begin
            n.div_cnt = q.div_cnt + 3'h1; // RL1
        end
        // delay line, sinc integrators on every modulator tick
        if (mod_tick) begin
            n.dec_cnt = dec_tick ? 11'h000 : q.dec_cnt + 11'h001;
            for (int c = 0; c < adc_backend_pkg::NUM_CH; c++) begin
                n.dline[c] = {q.dline[c][adc_backend_pkg::DLINE_LEN-2:0], q.mbit_s2[c]};
                step_bit = q.dline[c][q.delay[c]]; // RL7
                n.integ[c][0] = q.integ[c][0] + (step_bit ? 36'h000000001 : 36'hfffffffff); // RL2 RL3
                n.integ[c][1] = q.integ[c][1] + q.integ[c][0];
                n.integ[c][2] = q.integ[c][2] + q.integ[c][1];
            end
        end
        // sinc combs at the output rate, then hand the samples to the fir engine
        if (dec_tick) begin
            for (int c = 0; c < adc_backend_pkg::NUM_CH; c++) begin
                c1 = $signed(q.integ[c][2] - q.comb[c][0]);
                c2 = c1 - $signed(q.comb[c][1]);
                c3 = c2 - $signed(q.comb[c][2]);
                n.comb[c][0] = q.integ[c][2];
                n.comb[c][1] = c1;
                n.comb[c][2] = c2;
                n.pend[c] = to_sample(c3, q.rate_code); // RL3 RL5
            end
            // engine takes far fewer cycles than one output period, so it is always idle here
            if (q.fsm == adc_backend_pkg::ST_IDLE) begin
                n.fsm = adc_backend_pkg::ST_WRITE;
                n.ch = 2'h0;
            end
        end
        // fault tracking per channel, recovery counted in output periods
        for (int c = 0; c < adc_backend_pkg::NUM_CH; c++) begin
            if (q.cfg_fdis) begin
                n.fault_act[c] = 1'b0; // RL14
                n.fault_cnt[c] = '0;
            end else if (q.fpos_s2[c] | q.fneg_s2[c]) begin
                n.fault_act[c] = 1'b1; // RL13
                n.fault_dir[c] = q.fneg_s2[c];
                n.fault_cnt[c] = '0;
            end else if (q.fault_act[c] && dec_tick) begin
                if (q.fault_cnt[c] == adc_backend_pkg::FAULT_REC_LAST) begin
                    n.fault_act[c] = 1'b0; // RL19
                end else begin
                    n.fault_cnt[c] = q.fault_cnt[c] + 5'h01;
                end
            end
        end
        // fir engine: write newest sample, then multiply-accumulate nine taps
        unique case (q.fsm)
            adc_backend_pkg::ST_IDLE: begin
                n.fsm = n.fsm;
            end
            adc_backend_pkg::ST_WRITE: begin
                mem.wr_en = 1'b1;
                n.tap = 4'h0;
                n.acc = '0;
                n.fsm = adc_backend_pkg::ST_READ;
            end
            adc_backend_pkg::ST_READ: begin
                n.fsm = adc_backend_pkg::ST_MAC;
            end
            adc_backend_pkg::ST_MAC: begin
                n.acc = q.acc + 40'(adc_backend_pkg::fir_coef(q.tap) * $signed(mem.rd_data)); // RL4
                if (q.tap == adc_backend_pkg::FIR_LAST_TAP) begin
                    n.fsm = adc_backend_pkg::ST_STORE;
                end else begin
                    n.tap = q.tap + 4'h1;
                    n.fsm = adc_backend_pkg::ST_READ;
                end
            end
            adc_backend_pkg::ST_STORE: begin
                y = 48'($signed(q.acc) >>> adc_backend_pkg::FIR_SHIFT);
                cr = clip_to(y, adc_backend_pkg::FS_CODE); // RL11
                // clamping only touches this channel's own result
                if (q.fault_act[q.ch]) begin
                    cr = {1'b1, q.fault_dir[q.ch] ? 24'(-$signed({1'b0, adc_backend_pkg::FS_CODE}))
                                                  : adc_backend_pkg::FS_CODE}; // RL15 RL16
                end
                n.result[q.ch] = cr[23:0];
                n.clip[q.ch] = cr[24];
                if (q.ch == 2'h3) begin
                    n.ready = 1'b1; // RL12
                    n.ovf_clip = |{cr[24], q.clip[2:0]};
                    n.wptr = (q.wptr == adc_backend_pkg::FIR_LAST_TAP) ? 4'h0 : q.wptr + 4'h1;
                    n.fsm = adc_backend_pkg::ST_IDLE;
                end else begin
                    n.ch = q.ch + 2'h1;
                    n.fsm = adc_backend_pkg::ST_WRITE;
                end
            end
        endcase
        // apb: read data and error captured in the setup phase
        if (setup_ph) begin
            n.slverr = (PADDR_I[1:0] != 2'h0) || (PADDR_I > adc_backend_pkg::ADDR_DATA3);
            n.prdata = '0;
            if (PADDR_I == adc_backend_pkg::ADDR_CFG) begin
                n.prdata[adc_backend_pkg::CFG_XTAL_BIT] = q.cfg_xtal;
                n.prdata[adc_backend_pkg::CFG_FDIS_BIT] = q.cfg_fdis;
            end else if (PADDR_I == adc_backend_pkg::ADDR_RATE) begin
                n.prdata[adc_backend_pkg::RATE_W-1:0] = q.rate_code;
            end else if (PADDR_I == adc_backend_pkg::ADDR_DELAY) begin
                for (int c = 0; c < adc_backend_pkg::NUM_CH; c++) begin
                    n.prdata[8*c +: adc_backend_pkg::DELAY_W] = q.delay[c];
                end
            end else if (PADDR_I == adc_backend_pkg::ADDR_STATUS) begin
                n.prdata[adc_backend_pkg::STAT_CLK_BIT] = q.clk_valid;
                n.prdata[adc_backend_pkg::STAT_FAULT_BIT] = |q.fault_act;
                n.prdata[adc_backend_pkg::STAT_OVF_BIT] = q.ovf_clip;
                n.prdata[adc_backend_pkg::STAT_READY_BIT] = q.ready;
                n.prdata[adc_backend_pkg::STAT_PIN_BIT] = q.ovf_s2;
            end else if (PADDR_I >= adc_backend_pkg::ADDR_DATA0 && !n.slverr) begin
                n.prdata[adc_backend_pkg::SMP_W-1:0] = q.result[PADDR_I[3:2]];
            end
        end
        // apb writes take effect at the access edge
        if (access_ph && PWRITE_I && !q.slverr) begin
            if (PADDR_I == adc_backend_pkg::ADDR_CFG && PSTRB_I[0]) begin
                n.cfg_xtal = PWDATA_I[adc_backend_pkg::CFG_XTAL_BIT]; // RL8
                n.cfg_fdis = PWDATA_I[adc_backend_pkg::CFG_FDIS_BIT]; // RL14
            end
            if (PADDR_I == adc_backend_pkg::ADDR_RATE && PSTRB_I[0]) begin
                n.rate_code = PWDATA_I[adc_backend_pkg::RATE_W-1:0]; // RL6
            end
            if (PADDR_I == adc_backend_pkg::ADDR_DELAY) begin
                for (int c = 0; c < adc_backend_pkg::NUM_CH; c++) begin
                    if (PSTRB_I[c]) begin
                        n.delay[c] = PWDATA_I[8*c +: adc_backend_pkg::DELAY_W]; // RL7
                    end
                end
            end
        end
        // reading any result releases ready, but a new publish in the same cycle wins
        if (access_ph && !PWRITE_I && !q.slverr && PADDR_I >= adc_backend_pkg::ADDR_DATA0
                && !(q.fsm == adc_backend_pkg::ST_STORE && q.ch == 2'h3)) begin
            n.ready = 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (!RST_N_I) begin
            q <= '0;
            q.fsm <= adc_backend_pkg::ST_IDLE;
        end else begin
            q <= n;
        end
    end

    // overflow pin pulls low only while a clock proves the flag meaningful
    assign ovf_drive = q.clk_valid & (q.ovf_clip | (|q.fault_act)); // RL16 RL17
    assign OVERFLOW_FLAG_N_O = 1'b0; // RL18
    assign OVERFLOW_FLAG_N_OE_O = ~ovf_drive; // RL18
    assign FAULT_FLAG_N_O = ~(|q.fault_act); // RL13
    assign PROTECT_ENGAGE_O = q.fault_act; // RL13
    assign RESULT_READY_OUT_N_O = ~q.ready;
    // oscillator amplifier and buffer are released outside crystal mode
    assign CRYSTAL_DRIVE_PIN_O = ~q.osc_buf; // RL8
    assign CRYSTAL_DRIVE_PIN_OE_O = ~q.cfg_xtal; // RL8
    assign BUFFERED_OSC_OUT_O = q.osc_buf; // RL10
    assign BUFFERED_OSC_OUT_OE_O = ~q.cfg_xtal; // RL9
    assign PRDATA_O = q.prdata;
    assign PREADY_O = access_ph;
    assign PSLVERR_O = access_ph & q.slverr;

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (!RST_N_I);

    div_spacing_a: assert property (mod_tick |=> !mod_tick [*8]) // RL1
        else $error("modulator ticks closer than eight input clocks");
    xtal_write_a: assert property ((access_ph && PWRITE_I && !q.slverr && PADDR_I == adc_backend_pkg::ADDR_CFG
            && PSTRB_I[0]) |=> (q.cfg_xtal == $past(PWDATA_I[0]) && q.cfg_fdis == $past(PWDATA_I[1]))) // RL8
        else $error("configuration write not applied");
    buffered_osc_out_release_a: assert property (!q.cfg_xtal |-> (BUFFERED_OSC_OUT_OE_O && CRYSTAL_DRIVE_PIN_OE_O)) // RL9
        else $error("clock output driven with crystal disabled");
    fs_clip_a: assert property ($rose(q.ready) |-> ($signed(q.result[0]) <= $signed({1'b0, adc_backend_pkg::FS_CODE})
            && $signed(q.result[0]) >= -$signed({1'b0, adc_backend_pkg::FS_CODE}))) // RL11
        else $error("result outside full scale");
    ovf_with_ready_a: assert property ($rose(q.ovf_clip) |-> ($rose(q.ready) || $past(q.ready) == 1'b1)) // RL12
        else $error("overflow raised without a result publish");
    fault_disable_a: assert property (q.cfg_fdis |=> (FAULT_FLAG_N_O && PROTECT_ENGAGE_O == 4'h0)) // RL14
        else $error("fault reported while protection disabled");
    fault_with_ovf_a: assert property ((|q.fault_act && q.clk_valid) |-> !OVERFLOW_FLAG_N_OE_O) // RL16
        else $error("fault flag low without overflow flag");
    no_clock_release_a: assert property (!q.clk_valid |-> OVERFLOW_FLAG_N_OE_O) // RL17
        else $error("overflow driven without input clock");
    fault_recovery_a: assert property ($fell(q.fault_act[1]) |-> ($past(q.cfg_fdis)
            || ($past(q.fault_cnt[1]) == adc_backend_pkg::FAULT_REC_LAST && $past(dec_tick)))) // RL19
        else $error("fault released before recovery count");
    fault_immediate_a: assert property ((!q.cfg_fdis && q.fpos_s2[1]) |=> q.fault_act[1] ##0 !FAULT_FLAG_N_O) // RL13
        else $error("fault input did not raise fault flag");
endmodule : adc_backend
`default_nettype wire

// file: tb/apb_host_model.sv
// host side bus master that reaches the back end registers
`timescale 1ns/1ns
`default_nettype none
module apb_host_model (
    input wire logic clk_i,
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h0;
    end
    // one transfer; request held until pready is seen high at an edge
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] rd, output logic err);
        @(posedge clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= w;
        paddr_o <= a;
        pwdata_o <= d;
        @(posedge clk_i);
        penable_o <= 1'b1;
        do @(posedge clk_i); while (pready_i !== 1'b1);
        rd = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
    endtask : xfer
endmodule : apb_host_model
`default_nettype wire

// file: tb/tb.sv
// self-checking bench for the converter back end
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin error_cnt++; \
    $display("wrong value at %0t: %h expected %h", $time, a, b); end end
module tb;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic e;} row_t;
    logic clk, rst_n, osc_en, psel, pen, pwr, pready, perr, ovf_oe, rdy_n, flt_n, boe, coe;
    logic bclk, xdrv, ovf_d, b0;
    logic osc = 1'b0;
    // at every oscillator rise the bits read 0101, so ch0/ch2 sit at plus and ch1/ch3 at minus full scale
    logic [3:0] modb = 4'ha;
    logic [7:0] paddr;
    logic [31:0] pwd, prd, rd;
    logic [3:0] fpos, fneg, prot;
    logic err;
    int error_cnt = 0, tests_run = 0, n = 0, p;
    time t0;
    row_t rows[5] = '{'{1, 8'h04, 32'h0, 0}, '{1, 8'h00, 32'h1, 0}, '{0, 8'h20, 32'h0, 1},
                      '{0, 8'h02, 32'h0, 1}, '{1, 8'h24, 32'h5, 1}};
    adc_backend adc_backend_inst (.CORE_CLK_I(clk), .RST_N_I(rst_n), .PSEL_I(psel), .PENABLE_I(pen),
        .PWRITE_I(pwr), .PADDR_I(paddr), .PWDATA_I(pwd), .PSTRB_I(4'hf), .PRDATA_O(prd),
        .PREADY_O(pready), .PSLVERR_O(perr), .OSC_CLOCK_INPUT_I(osc), .CRYSTAL_DRIVE_PIN_O(xdrv),
        .CRYSTAL_DRIVE_PIN_OE_O(coe), .BUFFERED_OSC_OUT_O(bclk), .BUFFERED_OSC_OUT_OE_O(boe),
        .MOD_BITS_I(modb), .FAULT_POS_I(fpos), .FAULT_NEG_I(fneg), .PROTECT_ENGAGE_O(prot),
        .OVERFLOW_FLAG_N_I(ovf_oe), .OVERFLOW_FLAG_N_O(ovf_d), .OVERFLOW_FLAG_N_OE_O(ovf_oe),
        .FAULT_FLAG_N_O(flt_n), .RESULT_READY_OUT_N_O(rdy_n));
    apb_host_model apb_host_model_inst (.clk_i(clk), .psel_o(psel), .penable_o(pen), .pwrite_o(pwr),
        .paddr_o(paddr), .pwdata_o(pwd), .prdata_i(prd), .pready_i(pready), .pslverr_i(perr));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // external clock at 25 MHz, stopped until enabled
    always @(posedge clk) if (osc_en && (n % 2 == 0)) begin
        osc <= ~osc;
        modb <= ~modb;
    end
    always @(posedge clk) n <= n + 1;
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        apb_host_model_inst.xfer(w, a, d, rd, err);
    endtask : bus
    task automatic wait_rdy();
        int k;
        k = 0;
        do begin @(posedge clk); k++; end while (rdy_n !== 1'b0 && k < 5000);
        `CHK(rdy_n, 1'b0)
    endtask : wait_rdy
    // time between two result publishes; ready is cleared first so a stale flag cannot start the count
    task automatic period(output int q);
        bus(0, 8'h10, 0);
        wait_rdy();
        t0 = $time;
        bus(0, 8'h10, 0);
        wait_rdy();
        q = int'(($time - t0) / 10);
    endtask : period
    task automatic finish_test();
        $display("tests %0d errors %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : finish_test
    initial begin
        #800000;
        error_cnt++;
        finish_test();
    end
    initial begin
        rst_n = 1'b0;
        osc_en = 1'b0;
        fpos = 4'h0;
        fneg = 4'h0;
        repeat (3) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        #1;
        `CHK({boe, coe, ovf_oe, flt_n, rdy_n, ovf_d, prot, prd}, {6'h3e, 4'h0, 32'h0})
        $display("reset test done");
        foreach (rows[i]) begin
            bus(rows[i].w, rows[i].a, rows[i].d);
            `CHK(err, rows[i].e)
            if (rows[i].e) `CHK(rd, 32'h0)
        end
        `CHK({boe, coe}, 2'b00)
        bus(0, 8'h0c, 0);
        `CHK(rd[0], 1'b0)
        $display("register table done");
        osc_en <= 1;
        repeat (20) @(posedge clk);
        bus(0, 8'h0c, 0);
        `CHK(rd[0], 1'b1)
        // the oscillator toggles every second core cycle, so the buffered copy must too
        b0 = bclk;
        repeat (2) @(posedge clk);
        `CHK({bclk, xdrv}, {~b0, b0})
        period(p);
        `CHK(p, 512)
        bus(1, 8'h04, 1);
        period(p);
        period(p);
        `CHK(p, 1024)
        $display("rate test done");
        bus(1, 8'h00, 3);
        fpos <= 4'h2;
        fneg <= 4'h1;
        repeat (10) @(posedge clk);
        `CHK({flt_n, prot}, {1'b1, 4'h0})
        // let the rate-change glitch leave the nine-tap history before results are compared
        repeat (4) period(p);
        bus(1, 8'h00, 1);
        repeat (6) @(posedge clk);
        `CHK({flt_n, prot, ovf_oe}, {1'b0, 4'h3, 1'b0})
        period(p);
        bus(0, 8'h14, 0);
        `CHK(rd, {8'h00, adc_backend_pkg::FS_CODE})
        bus(0, 8'h10, 0);
        `CHK(rd, {8'h00, 24'h000000 - adc_backend_pkg::FS_CODE})
        bus(0, 8'h1c, 0);
        `CHK(rd, {8'h00, 24'h000000 - adc_backend_pkg::FS_CODE})
        fpos <= 4'h0;
        fneg <= 4'h0;
        repeat (20 * 1024) @(posedge clk);
        `CHK(flt_n, 1'b0)
        repeat (5 * 1024) @(posedge clk);
        `CHK(flt_n, 1'b1)
        $display("fault test done");
        finish_test();
    end
endmodule : tb
`default_nettype wire
